// *** core/octal_drv_pkg.sv ***
// Constants shared by the octal driver serial control core.
// Assumes a 250 MHz core clock sampling all serial pins.
package octal_drv_pkg;
   localparam int          CHANNELS      = 8;
   localparam logic [7:0]  LATCH_RESET   = 8'hFF;
   localparam logic [7:0]  SHIFT_RESET   = 8'h00;
   localparam logic [2:0]  SYNC_RESET    = 3'h0;
   localparam logic [2:0]  SYNC_SEL_RST  = 3'h7;
   localparam int          CLK_MHZ       = 250;
   localparam int          SCLK_MAX_KHZ  = 3000;
   localparam int          SCLK_MIN_CYC  = (CLK_MHZ * 1000) / SCLK_MAX_KHZ;
   localparam logic [3:0]  BIT_COUNT_MAX = 4'h8;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_SHIFT = 3'b010,
      ST_DONE  = 3'b100
   } frame_state_t;
endpackage

// *** core/pin_sync3.sv ***
// Three-stage synchroniser for one asynchronous pin.
// Assumes a single core clock; reports a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic CLOCK,
   input  wire logic RESET_N,
   input  wire logic pin_in,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic [2:0] sync_r;
   logic       level_r;
   wire        agree = (sync_r[1] == sync_r[2]);

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         sync_r  <= {3{RST_VAL}};
         level_r <= RST_VAL;
      end else begin
         sync_r  <= {sync_r[1:0], pin_in};
         if (agree) begin
            level_r <= sync_r[2];
         end
      end
   end

   assign level = level_r;
   assign rise  = agree && sync_r[2] && !level_r;
   assign fall  = agree && !sync_r[2] && level_r;
endmodule
`default_nettype wire

// *** core/octal_drv_serial.sv ***
// Serial control and diagnostic core of an eight-channel low-side driver.
// Assumes a fast core clock; the serial pins arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module octal_drv_serial
   import octal_drv_pkg::*;
(
   input  wire logic       CLOCK,
   input  wire logic       RESET_N,
   input  wire logic       UNDERVOLT,
   input  wire logic       SELECT_N,
   input  wire logic       SCLK,
   input  wire logic       SDI,
   output logic            SDO,
   output logic            SDO_OE_N,
   input  wire logic       FAULT_SHUTDOWN_MODE,
   input  wire logic [7:0] OVERCURRENT,
   input  wire logic [7:0] OVERTEMP,
   input  wire logic [7:0] OPEN_LOAD,
   output logic [7:0]      DRIVE_ON,
   output logic [7:0]      CURRENT_LIMIT,
   output logic [7:0]      FAULT_FLAGS,
   output logic            FRAME_DONE
);
   logic         sel_lvl;
   logic         sel_rise;
   logic         sel_fall;
   logic         clk_rise;
   logic         clk_fall;
   logic         sdi_lvl;
   logic [2:0]   uv_sync_r;
   logic [7:0]   shift_r;
   logic [7:0]   shift_nxt;
   logic [7:0]   latch_r;
   logic [7:0]   latch_nxt;
   logic [7:0]   trip_r;
   logic [7:0]   trip_nxt;
   logic         sdo_r;
   logic [3:0]   count_r;
   logic [3:0]   count_nxt;
   logic         done_r;
   frame_state_t state_r;
   frame_state_t state_nxt;

   pin_sync3 #(.RST_VAL(1'b1)) u_sel (
      .CLOCK   (CLOCK),
      .RESET_N (RESET_N),
      .pin_in  (SELECT_N),
      .level   (sel_lvl),
      .rise    (sel_rise),
      .fall    (sel_fall)
   );

   pin_sync3 #(.RST_VAL(1'b0)) u_clk (
      .CLOCK   (CLOCK),
      .RESET_N (RESET_N),
      .pin_in  (SCLK),
      .level   (),
      .rise    (clk_rise),
      .fall    (clk_fall)
   );

   pin_sync3 #(.RST_VAL(1'b0)) u_sdi (
      .CLOCK   (CLOCK),
      .RESET_N (RESET_N),
      .pin_in  (SDI),
      .level   (sdi_lvl),
      .rise    (),
      .fall    ()
   );

   // Undervoltage arrives asynchronously; the last two stages must both be high
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         uv_sync_r <= SYNC_RESET;
      end else begin
         uv_sync_r <= {uv_sync_r[1:0], UNDERVOLT};
      end
   end

   wire dev_reset = !RESET_N || (uv_sync_r[1] && uv_sync_r[2]);

   wire active    = !sel_lvl;
   wire cap_edge  = active && clk_fall && !sel_fall;
   wire out_edge  = active && clk_rise && !sel_fall;

   genvar g;
   logic [7:0] status_bits;
   logic [7:0] fault_now;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_chan
         wire open_det = latch_r[g] && OPEN_LOAD[g];
         wire hot      = OVERTEMP[g];
         wire on_cmd   = !latch_r[g];
         assign fault_now[g]   = open_det || hot || trip_r[g] ||
                                 (on_cmd && OVERCURRENT[g]);
         assign status_bits[g] = latch_r[g] ^ fault_now[g];
         // latched trip off
         // New trip wins over a clear in the same cycle
         assign trip_nxt[g]    = (trip_r[g] && !sel_rise) ||
                                 (!FAULT_SHUTDOWN_MODE && on_cmd && OVERCURRENT[g]);
         assign CURRENT_LIMIT[g] = FAULT_SHUTDOWN_MODE && on_cmd && OVERCURRENT[g];
         assign DRIVE_ON[g]      = on_cmd && !trip_r[g] && !hot;
      end
   endgenerate

   assign shift_nxt = sel_fall ? status_bits :
                      cap_edge ? {shift_r[6:0], sdi_lvl} : shift_r;

   assign latch_nxt = sel_rise ? shift_r : latch_r;

   assign count_nxt = sel_fall ? 4'h0 :
                      (cap_edge && count_r != BIT_COUNT_MAX) ? count_r + 4'h1 : count_r;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (sel_fall) begin
               state_nxt = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (sel_rise) begin
               state_nxt = ST_IDLE;
            end else if (count_nxt == BIT_COUNT_MAX) begin
               state_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            if (sel_rise) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (dev_reset) begin
         latch_r <= LATCH_RESET;
         trip_r  <= SHIFT_RESET;
         done_r  <= 1'b0;
      end else begin
         latch_r <= latch_nxt;
         trip_r  <= trip_nxt;
         done_r  <= sel_rise && (state_r == ST_DONE);
      end
   end

   // Shift register is kept out of reset on purpose; the output pin flop sdo_r still resets to 0
   always_ff @(posedge CLOCK) begin
      shift_r <= shift_nxt;
   end

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         count_r <= 4'h0;
         state_r <= ST_IDLE;
         sdo_r   <= 1'b0;
      end else begin
         count_r <= count_nxt;
         state_r <= state_nxt;
         if (sel_fall) begin
            sdo_r <= status_bits[7];
         end else if (out_edge) begin
            sdo_r <= shift_r[7];
         end
      end
   end

   assign SDO         = sdo_r;
   assign SDO_OE_N    = sel_lvl;
   assign FAULT_FLAGS = fault_now;
   assign FRAME_DONE  = done_r;
endmodule
`default_nettype wire

// *** tb/octal_drv_chk.sv ***
// Port-level checker for the octal driver serial core.
// Assumes it is bound to the core and shares its clock and reset.
`timescale 1ns/1ps
`default_nettype none
module octal_drv_chk (
   input wire logic       CLOCK,
   input wire logic       RESET_N,
   input wire logic       UNDERVOLT,
   input wire logic       SELECT_N,
   input wire logic       SCLK,
   input wire logic       SDO,
   input wire logic       SDO_OE_N,
   input wire logic       FAULT_SHUTDOWN_MODE,
   input wire logic [7:0] OVERCURRENT,
   input wire logic [7:0] OVERTEMP,
   input wire logic [7:0] DRIVE_ON,
   input wire logic [7:0] CURRENT_LIMIT,
   input wire logic       FRAME_DONE
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   oe_idle_a: assert property (SELECT_N [*5] |-> SDO_OE_N)
      else $error("serial output driven while deselected");
   oe_active_a: assert property (!SELECT_N [*7] |-> !SDO_OE_N)
      else $error("serial output not driven while selected");
   done_pulse_a: assert property (FRAME_DONE |=> !FRAME_DONE)
      else $error("frame done longer than one cycle");
   done_sel_a: assert property (FRAME_DONE |-> SELECT_N && !$past(SELECT_N, 7))
      else $error("frame done without recent select rise");
   // Sync lag allowed before the supply drop takes hold
   uv_off_a: assert property (UNDERVOLT [*6] |-> DRIVE_ON == 8'h00)
      else $error("outputs on during undervoltage");
   ot_off_a: assert property ((OVERTEMP & $past(OVERTEMP, 6) & DRIVE_ON) == 8'h00)
      else $error("overheated channel still on");
   lim_a: assert property (CURRENT_LIMIT != 8'h00 |->
      FAULT_SHUTDOWN_MODE && (CURRENT_LIMIT & ~OVERCURRENT) == 8'h00)
      else $error("current limit outside limit mode");
   drive_hold_a: assert property ((!SELECT_N [*8]) ##0 (!UNDERVOLT && $stable(OVERTEMP)
      && $stable(OVERCURRENT)) |-> $stable(DRIVE_ON))
      else $error("outputs changed inside a frame");
   sdo_hold_a: assert property ((!SCLK && !SELECT_N) [*8] |-> $stable(SDO))
      else $error("serial output moved without clock rise");
   cover property (FRAME_DONE);
   cover property (CURRENT_LIMIT != 8'h00);
   cover property ($fell(UNDERVOLT));
endmodule
`default_nettype wire

// *** tb/spi_host_model.sv ***
// Serial master model: drives select, clock and data.
// Assumes pin changes land on core clock rising edges.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input  wire logic clk,
   input  wire logic sdo,
   input  wire logic sdo_oe_n,
   output logic      select_n,
   output logic      sclk,
   output logic      sdi
);
   // Released line shows the inverse, so a missing enable is caught
   wire so_seen = sdo_oe_n ? ~sdo : sdo;
   initial begin
      select_n = 1'b1;
      sclk     = 1'b0;
      sdi      = 1'b0;
   end
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      select_n <= 1'b0;
      repeat (10) @(posedge clk);
      for (int i = 7; i >= 0; i--) begin
         sdi <= tx[i];
         repeat (2) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
         // Sample away from the edge that launches the serial output
         repeat (2) @(posedge clk);
         rx[i] = so_seen;
      end
      repeat (4) @(posedge clk);
      select_n <= 1'b1;
      sdi      <= ~sdi;
      repeat (8) @(posedge clk);
   endtask
   // broken on purpose: toggles while deselected
   task automatic idle_noise();
      repeat (6) begin
         sclk <= ~sclk;
         sdi  <= ~sdi;
         repeat (4) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// *** tb/tb_octal_drv_serial.sv ***
// Self-checking bench for the octal driver serial core.
// Assumes the host model and checker files compile first.
`timescale 1ns/1ps
`default_nettype none
module tb_octal_drv_serial;
   import octal_drv_pkg::*;
   logic       clock = 1'b0;
   logic       reset_n = 1'b0;
   logic       undervolt = 1'b0;
   logic       mode = 1'b0;
   logic [7:0] oc = 8'h00, ot = 8'h00, ol = 8'h00, rx;
   wire logic  select_n, sclk, sdi, sdo, sdo_oe_n, frame_done;
   wire logic [7:0] drive_on, cur_lim, flags;
   int         err_count = 0, check_count = 0, done_seen = 0;
   always #2 clock = ~clock;
   always @(posedge clock) if (frame_done === 1'b1) done_seen++;
   octal_drv_serial octal_drv_serial_i (.CLOCK(clock), .RESET_N(reset_n),
      .UNDERVOLT(undervolt), .SELECT_N(select_n), .SCLK(sclk), .SDI(sdi),
      .SDO(sdo), .SDO_OE_N(sdo_oe_n), .FAULT_SHUTDOWN_MODE(mode), .OVERCURRENT(oc),
      .OVERTEMP(ot), .OPEN_LOAD(ol), .DRIVE_ON(drive_on), .CURRENT_LIMIT(cur_lim),
      .FAULT_FLAGS(flags), .FRAME_DONE(frame_done));
   spi_host_model spi_host_model_i (.clk(clock), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
      .select_n(select_n),
      .sclk(sclk), .sdi(sdi));
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic t_frames();
      chk(drive_on, 8'h00);
      spi_host_model_i.xfer(8'h5A, rx);
      chk(rx, LATCH_RESET);
      chk(drive_on, 8'hA5);
      chk(done_seen[7:0], 8'h01);
      spi_host_model_i.xfer(8'h0F, rx);
      chk(rx, 8'h5A);
      chk(drive_on, 8'hF0);
      spi_host_model_i.idle_noise();
      chk({drive_on[7:1], sdo_oe_n}, 8'hF1);
      $display("frames done");
   endtask
   task automatic t_faults();
      ot <= 8'h80;
      cyc(8);
      chk(drive_on, 8'h70);
      spi_host_model_i.xfer(8'h0F, rx);
      chk(rx, 8'h8F);
      ot <= 8'h00;
      ol <= 8'h81;
      cyc(2);
      chk(flags, 8'h01);
      ol <= 8'h00;
      mode <= 1'b1;
      cyc(2);
      oc <= 8'h10;
      cyc(8);
      chk(cur_lim, 8'h10);
      oc <= 8'h00;
      cyc(2);
      mode <= 1'b0;
      oc <= 8'h10;
      cyc(8);
      oc <= 8'h00;
      cyc(8);
      chk(drive_on, 8'hE0);
      spi_host_model_i.xfer(8'h0F, rx);
      chk(drive_on, 8'hF0);
      undervolt <= 1'b1;
      cyc(10);
      chk(drive_on, 8'h00);
      undervolt <= 1'b0;
      $display("faults done");
   endtask
   initial begin
      cyc(3);
      reset_n <= 1'b1;
      cyc(5);
      t_frames();
      t_faults();
      summarize();
   end
   initial begin
      cyc(5000);
      err_count++;
      summarize();
   end
endmodule
bind octal_drv_serial octal_drv_chk octal_drv_chk_i (.CLOCK, .RESET_N, .UNDERVOLT,
   .SELECT_N, .SCLK, .SDO, .SDO_OE_N, .FAULT_SHUTDOWN_MODE, .OVERCURRENT,
   .OVERTEMP, .DRIVE_ON, .CURRENT_LIMIT, .FRAME_DONE);
`default_nettype wire
